// >>> verilog/icf_top.v
// isa cycle engine, fast disk strobe machine and disk pin steering
`timescale 1ns/1ps
`include "icf_regs.vh"
module icf_top (
	mclk,
	rst,
	cfg_load,
	cfg_dly_io,
	cfg_dly_m8,
	cfg_dly_m16,
	cfg_ws8_code,
	cfg_ws16,
	cfg_addr_hold,
	cfg_isa_half,
	cfg_fast_en,
	cfg_a2_sub_en,
	ide_setup,
	ide_cmd_len,
	ide_recov,
	cyc_start,
	cyc_io,
	cyc_wr,
	cyc_32,
	cyc_addr,
	cyc_sbhe_n,
	slave16,
	cache_hit,
	dram_hit,
	ldev_claim_n,
	boot_rom_select_n,
	onchip_xd_port,
	claim_route,
	cyc_ready,
	ide_word_half,
	isa_bus_clk,
	isa_ior_n,
	isa_iow_n,
	isa_memr_n,
	isa_memw_n,
	isa_cmd_oe,
	expansion_cycle_active,
	iochrdy,
	zero_ws_n,
	ext_ior_n,
	ext_iow_n,
	ext_addr,
	alt_master_grant_n,
	ext_local_hit,
	ext_xd_target,
	lb_master_en,
	lb_read,
	lb_write,
	byte_swap,
	xd_to_sd,
	dram_addr_in,
	periph_data_high,
	dram_mux_addr,
	xd_in,
	floppy_change_bit_in,
	rd_data,
	sysdata_buffer_enable_n,
	disk_read_strobe_n,
	disk_write_strobe_n,
	disk_select_cmd_n,
	disk_select_ctl_n,
	disk_buffer_enable_n,
	periph_addr_low,
	periph_addr_low_oe,
	byte_high_n,
	byte_high_oe
);
	input  wire        mclk;
	input  wire        rst;
	input  wire        cfg_load;
	input  wire [1:0]  cfg_dly_io;
	input  wire [1:0]  cfg_dly_m8;
	input  wire [1:0]  cfg_dly_m16;
	input  wire [1:0]  cfg_ws8_code;
	input  wire [1:0]  cfg_ws16;
	input  wire        cfg_addr_hold;
	input  wire [5:0]  cfg_isa_half;
	input  wire        cfg_fast_en;
	input  wire        cfg_a2_sub_en;
	input  wire [1:0]  ide_setup;
	input  wire [3:0]  ide_cmd_len;
	input  wire [3:0]  ide_recov;
	input  wire        cyc_start;
	input  wire        cyc_io;
	input  wire        cyc_wr;
	input  wire        cyc_32;
	input  wire [15:0] cyc_addr;
	input  wire        cyc_sbhe_n;
	input  wire        slave16;
	input  wire        cache_hit;
	input  wire        dram_hit;
	input  wire        ldev_claim_n;
	input  wire        boot_rom_select_n;
	input  wire        onchip_xd_port;
	output reg  [2:0]  claim_route;
	output wire        cyc_ready;
	output wire        ide_word_half;
	output wire        isa_bus_clk;
	output wire        isa_ior_n;
	output wire        isa_iow_n;
	output wire        isa_memr_n;
	output wire        isa_memw_n;
	output wire        isa_cmd_oe;
	output wire        expansion_cycle_active;
	input  wire        iochrdy;
	input  wire        zero_ws_n;
	input  wire        ext_ior_n;
	input  wire        ext_iow_n;
	input  wire [15:0] ext_addr;
	input  wire        alt_master_grant_n;
	input  wire        ext_local_hit;
	input  wire        ext_xd_target;
	output reg         lb_master_en;
	output reg         lb_read;
	output reg         lb_write;
	output reg         byte_swap;
	output reg         xd_to_sd;
	input  wire [7:0]  dram_addr_in;
	input  wire [7:0]  periph_data_high;
	output reg  [7:0]  dram_mux_addr;
	input  wire [7:0]  xd_in;
	input  wire        floppy_change_bit_in;
	output reg  [7:0]  rd_data;
	output reg         sysdata_buffer_enable_n;
	output reg         disk_read_strobe_n;
	output reg         disk_write_strobe_n;
	output reg         disk_select_cmd_n;
	output reg         disk_select_ctl_n;
	output reg         disk_buffer_enable_n;
	output reg  [1:0]  periph_addr_low;
	output wire        periph_addr_low_oe;
	output reg         byte_high_n;
	output wire        byte_high_oe;

	localparam [1:0] IS_IDLE = 2'h0;
	localparam [1:0] IS_RUN  = 2'h1;
	localparam [1:0] IS_HOLD = 2'h2;
	localparam [1:0] IS_DONE = 2'h3;
	localparam [2:0] FS_IDLE  = 3'h0;
	localparam [2:0] FS_SETUP = 3'h1;
	localparam [2:0] FS_CMD   = 3'h2;
	localparam [2:0] FS_DONE  = 3'h3;
	localparam integer HALF_FULL = `ICF_ISA_HALF_CYC;
	localparam [5:0] HALF_RST = HALF_FULL[5:0];

	// configuration held here so defaults apply from reset
	reg [1:0] dly_io_reg;
	reg [1:0] dly_m8_reg;
	reg [1:0] dly_m16_reg;
	reg [1:0] ws8_reg;
	reg [1:0] ws16_reg;
	reg       ahold_reg;
	reg [5:0] half_reg;
	always @(posedge mclk) begin
		if (rst) begin
			dly_io_reg  <= `ICF_DLY_IO_RST;
			dly_m8_reg  <= `ICF_DLY_M8_RST;
			dly_m16_reg <= `ICF_DLY_M16_RST;
			ws8_reg     <= `ICF_WS8_CODE_RST;
			ws16_reg    <= `ICF_WS16_RST;
			ahold_reg   <= `ICF_AHOLD_RST;
			half_reg    <= HALF_RST;
		end else if (cfg_load) begin
			dly_io_reg  <= cfg_dly_io;
			dly_m8_reg  <= cfg_dly_m8;
			dly_m16_reg <= cfg_dly_m16;
			ws8_reg     <= cfg_ws8_code;
			ws16_reg    <= cfg_ws16;
			ahold_reg   <= cfg_addr_hold;
			half_reg    <= (cfg_isa_half == 6'h00) ? 6'h01 : cfg_isa_half;
		end
	end

	// ready, zero wait and external command pins and the floppy bit pass the synchroniser
	wire [4:0] pin_s;
	icf_sync3 #(.W(5), .RST(1'b1)) u_sync (
		.mclk (mclk),
		.rst  (rst),
		.d    ({iochrdy, zero_ws_n, ext_ior_n, ext_iow_n,
		        floppy_change_bit_in}),
		.q    (pin_s)
	);
	wire rdy_s    = pin_s[4];
	wire zws_n_s  = pin_s[3];
	wire eior_n_s = pin_s[2];
	wire eiow_n_s = pin_s[1];
	wire floppy_s = pin_s[0];
	wire grant    = ~alt_master_grant_n;

	// bus clock divider; a zero divisor is loaded as one
	reg [5:0] div_reg;
	reg       bclk_reg;
	wire      half_tick = (div_reg == half_reg - 6'h01);
	always @(posedge mclk) begin
		if (rst) begin
			div_reg  <= 6'h00;
			bclk_reg <= 1'b0;
		end else begin
			div_reg  <= half_tick ? 6'h00 : div_reg + 6'h01;
			if (half_tick)
				bclk_reg <= ~bclk_reg;
		end
	end
	assign isa_bus_clk = bclk_reg;

	// cycle attributes latched when a cycle is offered
	reg        io_reg;
	reg        wr_reg;
	reg        w32_reg;
	reg        s16_reg;
	reg        sbhe_reg;
	reg [15:0] addr_reg;
	wire cs0_c = (cyc_addr[15:3] == `ICF_CS0_BASE);
	wire fast_c = cfg_fast_en & cyc_io & cs0_c & (cyc_addr[2:0] == 3'h0);
	reg  [2:0] route_c;
	// fixed claim priority; i/o may only be taken by a local slave or the fast disk machine
	always @* begin
		if (cache_hit & ~cyc_io)
			route_c = `ICF_RT_CACHE;
		else if (dram_hit & ~cyc_io)
			route_c = `ICF_RT_DRAM;
		else if (~ldev_claim_n)
			route_c = `ICF_RT_LOCAL;
		else if (~boot_rom_select_n & ~cyc_io)
			route_c = `ICF_RT_ROM;
		else if (fast_c & ~grant)
			route_c = `ICF_RT_FAST;
		else
			route_c = `ICF_RT_ISA;
	end

	// isa cycle machine, counting half bus clocks
	reg [1:0] is_reg;
	reg [3:0] hc_reg;
	reg       onchip_reg;
	wire [1:0] dly_sel = io_reg ? dly_io_reg :
		(s16_reg ? dly_m16_reg : dly_m8_reg);
	wire [3:0] ws_sel = s16_reg ? {2'h0, ws16_reg} :
		({2'h0, ws8_reg} + `ICF_WS8_MIN);
	wire [3:0] end_h = {ws_sel[2:0], 1'b0} + 4'h4;
	// command opens after the two start halves, so zero delay is one clock;
	// a delay of two or more halves in a zero wait 16-bit cycle leaves no command at all
	wire cmd_on = (is_reg == IS_RUN) &
		(hc_reg >= {2'h0, dly_sel} + 4'h2);
	wire last_h = (hc_reg == end_h - 4'h1) & rdy_s;
	wire early  = ~zws_n_s & cmd_on & (hc_reg >= 4'h1);
	wire start  = cyc_start & (is_reg == IS_IDLE);
	always @(posedge mclk) begin
		if (rst) begin
			is_reg      <= IS_IDLE;
			hc_reg      <= 4'h0;
			claim_route <= `ICF_RT_NONE;
			io_reg      <= 1'b0;
			wr_reg      <= 1'b0;
			w32_reg     <= 1'b0;
			s16_reg     <= 1'b0;
			sbhe_reg    <= 1'b1;
			addr_reg    <= 16'h0000;
			onchip_reg  <= 1'b0;
		end else begin
			if (start) begin
				claim_route <= route_c;
				io_reg      <= cyc_io;
				wr_reg      <= cyc_wr;
				w32_reg     <= cyc_32;
				s16_reg     <= slave16;
				sbhe_reg    <= cyc_sbhe_n;
				addr_reg    <= cyc_addr;
				onchip_reg  <= onchip_xd_port;
			end
			case (is_reg)
			IS_IDLE: begin
				hc_reg <= 4'h0;
				if (start & (route_c == `ICF_RT_ISA) & ~grant)
					is_reg <= IS_RUN;
			end
			IS_RUN: begin
				if (half_tick) begin
					if (last_h | early)
						is_reg <= ahold_reg ? IS_HOLD : IS_DONE;
					else if (hc_reg != end_h - 4'h1)
						hc_reg <= hc_reg + 4'h1;
				end
			end
			IS_HOLD: is_reg <= IS_DONE;
			IS_DONE: is_reg <= IS_IDLE;
			default: is_reg <= IS_IDLE;
			endcase
		end
	end
	assign expansion_cycle_active = (is_reg != IS_IDLE);
	// commands float while an alternate master owns the bus
	assign isa_cmd_oe = ~grant;
	assign isa_ior_n  = ~(cmd_on & io_reg & ~wr_reg);
	assign isa_iow_n  = ~(cmd_on & io_reg & wr_reg);
	assign isa_memr_n = ~(cmd_on & ~io_reg & ~wr_reg);
	assign isa_memw_n = ~(cmd_on & ~io_reg & wr_reg);

	// fast data port machine on the local clock
	reg [2:0] fs_reg;
	reg [3:0] fcnt_reg;
	reg       fhold_reg;
	reg       fhalf_reg;
	reg [3:0] dflt_cnt_reg;
	reg [3:0] rec_cnt_reg;
	wire dflt_on = ~expansion_cycle_active & ~grant;
	wire f_cmd   = (fs_reg == FS_CMD);
	wire f_rd    = f_cmd & ~wr_reg;
	wire f_wr    = f_cmd & wr_reg;
	wire ext_io  = grant & (~eior_n_s | ~eiow_n_s);
	wire any_cmd = f_cmd | ~isa_ior_n | ~isa_iow_n | ext_io;
	wire f_go    = (dflt_cnt_reg > {2'h0, ide_setup}) &
		(rec_cnt_reg >= ide_recov);
	always @(posedge mclk) begin
		if (rst) begin
			fs_reg       <= FS_IDLE;
			fcnt_reg     <= 4'h0;
			fhold_reg    <= 1'b0;
			fhalf_reg    <= 1'b0;
			dflt_cnt_reg <= 4'h0;
			rec_cnt_reg  <= 4'hf;
		end else begin
			// how long the address defaults have stood, saturating
			if (~dflt_on)
				dflt_cnt_reg <= 4'h0;
			else if (dflt_cnt_reg != 4'hf)
				dflt_cnt_reg <= dflt_cnt_reg + 4'h1;
			// recovery time since any isa or external i/o command or fast strobe, saturating
			if (any_cmd)
				rec_cnt_reg <= 4'h0;
			else if (rec_cnt_reg != 4'hf)
				rec_cnt_reg <= rec_cnt_reg + 4'h1;
			case (fs_reg)
			FS_IDLE: begin
				fhalf_reg <= 1'b0;
				if (start & (route_c == `ICF_RT_FAST))
					fs_reg <= FS_SETUP;
			end
			FS_SETUP: begin
				if (f_go) begin
					fs_reg   <= FS_CMD;
					fcnt_reg <= ide_cmd_len;
				end
			end
			FS_CMD: begin
				if (fcnt_reg != 4'h0)
					fcnt_reg <= fcnt_reg - 4'h1;
				else if (~rdy_s)
					fhold_reg <= 1'b1;
				else if (fhold_reg)
					fhold_reg <= 1'b0;
				else if (w32_reg & ~fhalf_reg) begin
					fhalf_reg <= 1'b1;
					fs_reg    <= FS_SETUP;
				end else
					fs_reg <= FS_DONE;
			end
			FS_DONE: fs_reg <= FS_IDLE;
			default: fs_reg <= FS_IDLE;
			endcase
		end
	end
	assign ide_word_half = fhalf_reg;
	assign cyc_ready = (is_reg == IS_DONE) | (fs_reg == FS_DONE);

	// disk pin group, address from the owner of the bus
	wire [15:0] sel_addr = grant ? ext_addr : addr_reg;
	wire cs0_hit = (sel_addr[15:3] == `ICF_CS0_BASE);
	wire cs1_hit = (sel_addr[15:1] == `ICF_CS1_BASE);
	wire disk_hit = cs0_hit | cs1_hit;
	wire io_rd = grant ? ~eior_n_s : ~isa_ior_n;
	wire io_wr = grant ? ~eiow_n_s : ~isa_iow_n;
	wire flop_port = (addr_reg == `ICF_FLOPPY_A) |
		(addr_reg == `ICF_FLOPPY_B);
	always @(posedge mclk) begin
		if (rst) begin
			disk_read_strobe_n   <= 1'b1;
			disk_write_strobe_n  <= 1'b1;
			disk_buffer_enable_n <= 1'b1;
			disk_select_cmd_n    <= 1'b0;
			disk_select_ctl_n    <= 1'b1;
			periph_addr_low      <= 2'h0;
			byte_high_n          <= 1'b0;
		end else begin
			// active-low or: either source pulls the strobe
			disk_read_strobe_n  <= ~((io_rd & disk_hit) | f_rd);
			disk_write_strobe_n <= ~((io_wr & disk_hit) | f_wr);
			disk_buffer_enable_n <= ~(((io_rd | io_wr) & disk_hit) |
				(fs_reg == FS_SETUP) | f_cmd);
			if (dflt_on) begin
				disk_select_cmd_n <= 1'b0;
				disk_select_ctl_n <= 1'b1;
				periph_addr_low   <= 2'h0;
				byte_high_n       <= 1'b0;
			end else begin
				disk_select_cmd_n <= ~cs0_hit;
				disk_select_ctl_n <= ~cs1_hit;
				periph_addr_low   <= sel_addr[1:0];
				byte_high_n <= (cfg_a2_sub_en & disk_hit & ~grant) ?
					addr_reg[2] : sbhe_reg;
			end
		end
	end
	// low address and byte high come from outside under grant
	assign periph_addr_low_oe = ~grant;
	assign byte_high_oe       = ~grant;

	// data steering and alternate master translation
	wire rd_cyc = expansion_cycle_active & ~wr_reg;
	always @(posedge mclk) begin
		if (rst) begin
			dram_mux_addr           <= 8'h00;
			rd_data                 <= 8'h00;
			sysdata_buffer_enable_n <= 1'b0;
			byte_swap               <= 1'b0;
			xd_to_sd                <= 1'b0;
			lb_master_en            <= 1'b0;
			lb_read                 <= 1'b0;
			lb_write                <= 1'b0;
		end else begin
			// shared lines: data high byte on isa, row/column otherwise
			dram_mux_addr <= expansion_cycle_active ?
				periph_data_high : dram_addr_in;
			// the system data bus is shut off when another source answers
			sysdata_buffer_enable_n <= rd_cyc & io_reg &
				(onchip_reg | disk_hit | flop_port);
			// read data taken only while the command stands; the slave
			// releases the bus as soon as the command ends
			if (cmd_on & io_reg & ~wr_reg & flop_port)
				rd_data <= {floppy_s, xd_in[6:0]};
			else if (cmd_on & ~wr_reg)
				rd_data <= xd_in;
			// high byte of a 16-bit master lands on the low lane
			byte_swap    <= grant & ~ext_local_hit & ~slave16 &
				ext_addr[0];
			xd_to_sd     <= grant & ~ext_local_hit & ext_xd_target;
			lb_master_en <= grant & ext_local_hit;
			lb_read      <= grant & ext_local_hit & ~eior_n_s;
			lb_write     <= grant & ext_local_hit & ~eiow_n_s;
		end
	end
endmodule

// >>> include/icf_regs.vh
// constants for the isa cycle and fast disk control block
// Contract
// - claim order: cache, dram, local slave, boot rom, otherwise isa; code puts the fast disk machine before isa
// - unclaimed i/o reads of on-chip or xd peripherals block system data bus
// - isa bus clock divided from chip clock, nominally about 8 mhz
// - dram mux lines carry peripheral data high byte during isa cycles
// - command delay 0..3 per i/o, 8-bit and 16-bit memory; 0 at ale
// - each delay unit postpones command half bus clock; end unchanged
// - delay defaults: 0 for 16-bit memory, 1 for i/o and 8-bit memory
// - wait states 2..5 for 8-bit, 0..3 for 16-bit; iochrdy, 0ws adjust
// - zero wait states gives two bus clock cycle; each adds one clock
// - wait state defaults: four for 8-bit, one for 16-bit
// - address hold option delays ready one clock after command ends
// - alternate master to isa slaves: byte swap and steer xd buffers
// - under grant float isa commands and drive local bus controls
// - 32-bit disk data port access becomes two 16-bit disk cycles
// - disk strobes combine isa i/o commands with fast machine strobes
// - fast machine drives strobes only for data port accesses
// - disk buffer enable from isa i/o to disk or fast machine access
// - select 0 decodes 1f0-1f7, select 1 decodes 3f6-3f7
// - idle: select 1 high, select 0, low address and a2 low
// - isa cycles decode selects; under grant low address comes from outside
// - when enabled put a2 on byte high enable for disk ports
// - reads of 3f7 or 377 take bit 7 from floppy change input
// - ready sampled before fast command end; hold until one clock after high
// - idle defaults only with no isa cycle and grant deasserted
`ifndef ICF_REGS_VH
`define ICF_REGS_VH
`define ICF_MCLK_KHZ      200000
`define ICF_ISA_NOM_KHZ   8000
`define ICF_ISA_HALF_CYC  ((`ICF_MCLK_KHZ + 2*`ICF_ISA_NOM_KHZ - 1) / (2*`ICF_ISA_NOM_KHZ))
`define ICF_DLY_IO_RST    2'h1
`define ICF_DLY_M8_RST    2'h1
`define ICF_DLY_M16_RST   2'h0
`define ICF_WS8_MIN       4'h2
`define ICF_WS8_CODE_RST  2'h2
`define ICF_WS16_RST      2'h1
`define ICF_AHOLD_RST     1'h0
`define ICF_CS0_BASE      13'h003e
`define ICF_CS1_BASE      15'h01fb
`define ICF_FLOPPY_A      16'h03f7
`define ICF_FLOPPY_B      16'h0377
`define ICF_RT_NONE       3'h0
`define ICF_RT_CACHE      3'h1
`define ICF_RT_DRAM       3'h2
`define ICF_RT_LOCAL      3'h3
`define ICF_RT_ROM        3'h4
`define ICF_RT_ISA        3'h5
`define ICF_RT_FAST       3'h6
`endif

// >>> verilog/icf_sync3.v
// three stage pin synchroniser, change accepted when stages two and three agree
`timescale 1ns/1ps
module icf_sync3 #(
	parameter W   = 1,
	parameter RST = 1'b1
) (
	mclk,
	rst,
	d,
	q
);
	input  wire         mclk;
	input  wire         rst;
	input  wire [W-1:0] d;
	output wire [W-1:0] q;

	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			reg s1_reg;
			reg s2_reg;
			reg s3_reg;
			reg q_reg;
			// first stage feeds only the second
			always @(posedge mclk) begin
				if (rst) begin
					s1_reg <= RST;
					s2_reg <= RST;
					s3_reg <= RST;
					q_reg  <= RST;
				end else begin
					s1_reg <= d[i];
					s2_reg <= s1_reg;
					s3_reg <= s2_reg;
					if (s2_reg == s3_reg)
						q_reg <= s3_reg;
				end
			end
			assign q[i] = q_reg;
		end
	endgenerate
endmodule

// >>> testbench/icf_properties.sv
// concurrent checks on the isa cycle and fast disk block ports
`timescale 1ns/1ps
`include "icf_regs.vh"
module icf_properties (
	input wire       mclk,
	input wire       rst,
	input wire       cyc_start,
	input wire       cyc_ready,
	input wire [2:0] claim_route,
	input wire       ide_word_half,
	input wire       isa_cmd_oe,
	input wire       expansion_cycle_active,
	input wire       alt_master_grant_n,
	input wire       disk_read_strobe_n,
	input wire       disk_write_strobe_n,
	input wire       disk_select_cmd_n,
	input wire       disk_select_ctl_n,
	input wire [1:0] periph_addr_low,
	input wire       periph_addr_low_oe,
	input wire       byte_high_n,
	input wire       byte_high_oe
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_cmd_float_grant: assert property (
		isa_cmd_oe == alt_master_grant_n) else $error("command drive vs grant");
	a_addr_src_grant: assert property (
		periph_addr_low_oe == alt_master_grant_n &&
		byte_high_oe == alt_master_grant_n) else $error("address drive vs grant");
	// three idle cycles leave room for the registered pins to settle
	a_idle_defaults: assert property (
		(!expansion_cycle_active && alt_master_grant_n) [*3] |->
		disk_select_ctl_n && !disk_select_cmd_n &&
		periph_addr_low == 2'h0 && !byte_high_n) else $error("idle defaults");
	a_ready_single: assert property (
		cyc_ready |=> !cyc_ready) else $error("ready longer than a cycle");
	a_ready_bound: assert property (
		$rose(expansion_cycle_active) |-> ##[1:700] cyc_ready)
		else $error("isa cycle never ended");
	a_route_hold: assert property (
		!cyc_start |=> $stable(claim_route)) else $error("route moved");
	a_ready_route: assert property (
		cyc_ready |-> claim_route == `ICF_RT_ISA ||
		claim_route == `ICF_RT_FAST) else $error("ready for claimed cycle");
	a_strobe_excl: assert property (
		!(!disk_read_strobe_n && !disk_write_strobe_n))
		else $error("both disk strobes low");
	a_half_fast: assert property (
		ide_word_half |-> claim_route == `ICF_RT_FAST)
		else $error("word half outside fast access");
endmodule
bind icf_top icf_properties icf_properties_i (.*);

// >>> testbench/icf_drive_model.sv
// isa slave and disk drive stand-in: read data and ready stretching
`timescale 1ns/1ps
module icf_drive_model #(
	parameter logic [7:0] DATA = 8'hb5
) (
	input  logic       mclk,
	input  logic       slow,
	input  logic       rd_n,
	output logic       iochrdy,
	output logic [7:0] xd_in
);
	logic [4:0] cnt;
	initial begin
		cnt = 5'h00;
		iochrdy = 1'b1;
	end
	// released bus shows the inverse so a late sample cannot pass
	assign xd_in = rd_n ? ~DATA : DATA;
	// slow mode holds ready low for the first 24 clocks of each read command
	always @(posedge mclk) begin
		cnt <= rd_n ? 5'h00 : cnt + {4'h0, cnt != 5'h1f};
		iochrdy <= !(slow && !rd_n && cnt < 5'h18);
	end
endmodule

// >>> testbench/tb_isa_cycle_and_fast_ide_control.sv
// self-checking bench for the isa cycle and fast disk block
`timescale 1ns/1ps
`include "icf_regs.vh"
module tb_isa_cycle_and_fast_ide_control;
	logic mclk, rst, cfg_load, cfg_addr_hold, cfg_fast_en, cfg_a2_sub_en;
	logic [1:0] cfg_dly_io, cfg_dly_m8, cfg_dly_m16, cfg_ws8_code, cfg_ws16;
	logic [5:0] cfg_isa_half;
	logic [1:0] ide_setup, periph_addr_low;
	logic [3:0] ide_cmd_len, ide_recov;
	logic cyc_start, cyc_io, cyc_wr, cyc_32, cyc_sbhe_n, slave16, cache_hit;
	logic dram_hit, ldev_claim_n, boot_rom_select_n, onchip_xd_port;
	logic [15:0] cyc_addr, ext_addr;
	logic [2:0] claim_route;
	logic cyc_ready, ide_word_half, isa_bus_clk, isa_ior_n, isa_iow_n;
	logic isa_memr_n, isa_memw_n, isa_cmd_oe, expansion_cycle_active;
	logic iochrdy, zero_ws_n, ext_ior_n, ext_iow_n, alt_master_grant_n;
	logic ext_local_hit, ext_xd_target, lb_master_en, lb_read, lb_write;
	logic byte_swap, xd_to_sd, floppy_change_bit_in, sysdata_buffer_enable_n;
	logic [7:0] dram_addr_in, periph_data_high, dram_mux_addr, xd_in, rd_data;
	logic disk_read_strobe_n, disk_write_strobe_n, disk_select_cmd_n;
	logic disk_select_ctl_n, disk_buffer_enable_n, periph_addr_low_oe;
	logic byte_high_n, byte_high_oe, slow;
	logic f_sd, f_cs0, f_cs1, f_en, f_bh, f_ma, f_half, f_isa;
	int err_count, tests_run, len, clo, sfall, smax, sl, base, cbase, b8, i;
	logic [3:0] hv[5] = '{4'hc, 4'h4, 4'h0, 4'h2, 4'hc};
	logic [2:0] rv[5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h3};

	icf_top icf_top_i (.*);
	icf_drive_model icf_drive_model_i (.mclk(mclk), .slow(slow),
		.rd_n(disk_read_strobe_n & isa_ior_n & isa_memr_n),
		.iochrdy(iochrdy), .xd_in(xd_in));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	task complete_run();
		if (err_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input logic c, input string m);
		tests_run++;
		if (c !== 1'b1) begin
			err_count++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	// inputs always move one ns after the rising edge
	task tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task cfg(input [1:0] w8, w16, d16, input h);
		{cfg_ws8_code, cfg_ws16, cfg_dly_m16, cfg_addr_hold} = {w8, w16, d16, h};
		cfg_load = 1'b1;
		tick(1);
		cfg_load = 1'b0;
		tick(1);
	endtask
	// mode bits: io, write, 32-bit, 16-bit slave, on-chip port, sbhe_n
	task offer(input [5:0] m, input [15:0] a, input [3:0] hits);
		{cache_hit, dram_hit, ldev_claim_n, boot_rom_select_n} = hits;
		{cyc_io, cyc_wr, cyc_32, slave16, onchip_xd_port, cyc_sbhe_n} = m;
		cyc_addr = a;
		cyc_start = 1'b1;
		tick(1);
		cyc_start = 1'b0;
	endtask
	// run one unclaimed cycle and record what the pins did until ready
	task run(input [5:0] m, input [15:0] a);
		{len, clo, sfall, smax, sl} = 0;
		{f_sd, f_cs0, f_cs1, f_en, f_bh, f_ma, f_half, f_isa} = 8'h00;
		// start on a bus clock edge so lengths do not hang on divider phase
		@(isa_bus_clk);
		#1;
		offer(m, a, 4'h3);
		while (cyc_ready !== 1'b1 && len < 3000) begin
			len++;
			clo += !(isa_ior_n && isa_memr_n && isa_iow_n);
			sl = disk_read_strobe_n ? 0 : sl + 1;
			sfall += (sl == 1);
			smax = sl > smax ? sl : smax;
			f_sd |= sysdata_buffer_enable_n === 1'b1;
			f_cs0 |= expansion_cycle_active && disk_select_cmd_n === 1'b0;
			f_cs1 |= disk_select_ctl_n === 1'b0;
			f_en |= disk_buffer_enable_n === 1'b0;
			f_bh |= byte_high_n === 1'b1;
			f_ma |= expansion_cycle_active && dram_mux_addr === periph_data_high;
			f_half |= ide_word_half === 1'b1;
			f_isa |= isa_ior_n === 1'b0;
			tick(1);
		end
		chk(cyc_ready === 1'b1, "no ready");
		tick(3);
	endtask

	initial begin
		{cfg_load, cfg_addr_hold, cfg_fast_en, cfg_a2_sub_en} = 4'h0;
		{cfg_dly_io, cfg_dly_m8, cfg_dly_m16, cfg_ws8_code, cfg_ws16} = 10'h000;
		{cfg_isa_half, ide_setup, ide_cmd_len, ide_recov} = 16'h3432;
		{cyc_start, cyc_io, cyc_wr, cyc_32, cyc_sbhe_n, slave16} = 6'h00;
		{cache_hit, dram_hit, ldev_claim_n, boot_rom_select_n} = 4'h3;
		{onchip_xd_port, cyc_addr, ext_addr} = 33'h0;
		{zero_ws_n, ext_ior_n, ext_iow_n, alt_master_grant_n} = 4'hf;
		{ext_local_hit, ext_xd_target, floppy_change_bit_in, slow} = 4'h0;
		{dram_addr_in, periph_data_high} = 16'h5ac3;
		{err_count, tests_run} = 0;
		rst = 1'b1;
		tick(16);
		rst = 1'b0;
		tick(4);
		chk(disk_select_ctl_n === 1'b1 && disk_select_cmd_n === 1'b0 &&
			periph_addr_low === 2'h0 && byte_high_n === 1'b0 &&
			dram_mux_addr === dram_addr_in, "idle pins");
		for (i = 0; i < 5; i++) begin
			offer(i == 4 ? 6'h20 : 6'h00, 16'h0400, hv[i]);
			tick(2);
			chk(claim_route === rv[i], "claim order");
		end
		// reset timing must match the documented default settings
		run(6'h04, 16'h0400);
		{base, cbase} = {len, clo};
		run(6'h00, 16'h0400);
		b8 = len;
		cfg(2'h2, 2'h1, 2'h0, 1'b0);
		run(6'h04, 16'h0400);
		chk(len == base && clo == cbase, "16-bit defaults");
		run(6'h00, 16'h0400);
		chk(len == b8, "8-bit defaults");
		for (i = 0; i < 4; i++) begin
			cfg(2'(i), 2'(i), 2'h0, 1'b0);
			run(6'h04, 16'h0400);
			base = i == 0 ? len : base;
			chk(len == base + 26 * i, "16-bit wait states");
			chk(i != 0 || (len == 51 && clo == 26), "zero wait cycle");
			run(6'h00, 16'h0400);
			b8 = i == 0 ? len : b8;
			chk(len == b8 + 26 * i, "8-bit wait states");
		end
		for (i = 0; i < 4; i++) begin
			cfg(2'h2, 2'h1, 2'(i), 1'b0);
			run(6'h04, 16'h0400);
			{base, cbase} = i == 0 ? {len, clo} : {base, cbase};
			chk(len == base && clo == cbase - 13 * i, "command delay");
		end
		cfg(2'h2, 2'h1, 2'h0, 1'b1);
		run(6'h04, 16'h0400);
		chk(len == base + 1, "address hold");
		cfg(2'h2, 2'h1, 2'h0, 1'b0);
		zero_ws_n = 1'b0;
		run(6'h04, 16'h0400);
		chk(len == base - 39, "zero wait shortening");
		zero_ws_n = 1'b1;
		for (i = 0; i < 2; i++) begin
			floppy_change_bit_in = i[0];
			run(6'h24, i == 0 ? 16'h03f7 : 16'h0377);
			chk(rd_data === {i[0], 7'h35} && f_sd, "shared bit 7");
		end
		chk(f_ma, "mux lines carry data");
		run(6'h24, 16'h03f7);
		chk(f_cs1 && f_en && f_isa && sfall == 1, "control port");
		run(6'h30, 16'h03f7);
		chk(f_en, "control port write");
		run(6'h22, 16'h0060);
		chk(f_sd, "on-chip port read");
		cfg_a2_sub_en = 1'b1;
		run(6'h24, 16'h01f4);
		chk(f_cs0 && !f_cs1 && f_bh && sfall == 1, "command port");
		cfg_fast_en = 1'b1;
		run(6'h2c, 16'h01f0);
		chk(claim_route === `ICF_RT_FAST && sfall == 2 && f_half, "split");
		chk(!f_isa && smax == 4 && f_en, "fast strobes");
		// a longer command lets the stretched ready reach the machine in time
		slow = 1'b1;
		ide_cmd_len = 4'h8;
		run(6'h2c, 16'h01f0);
		chk(smax > 24 && sfall == 2, "ready stretch");
		slow = 1'b0;
		{alt_master_grant_n, ext_addr, ext_local_hit, ext_ior_n} = 19'h007c6;
		tick(8);
		chk(isa_cmd_oe === 1'b0 && lb_master_en === 1'b1 &&
			lb_read === 1'b1, "grant");
		chk(disk_read_strobe_n === 1'b0 && disk_buffer_enable_n === 1'b0 &&
			periph_addr_low === 2'h1, "external read");
		{ext_local_hit, slave16, ext_xd_target} = 3'h1;
		tick(2);
		chk(byte_swap === 1'b1 && xd_to_sd === 1'b1, "byte swap");
		{ext_ior_n, alt_master_grant_n} = 2'h3;
		tick(8);
		complete_run();
	end

	// watchdog, well beyond the expected run of some 15 us
	initial begin
		#400000;
		err_count++;
		complete_run();
	end
endmodule
